// file: icce_pkg.sv
// Shared constants, word layouts and carriers of the channel command engine.
// Assumes a 32-bit word memory behind an access director, 19-bit addresses.
package icce_pkg;

  // ==========================================================================
  // Sizes
  localparam int CH_N = 8;
  localparam int CH_W = 3;
  localparam int AW   = 19;

  // ==========================================================================
  // Command operation codes
  localparam logic [3:0] OP_CTLPROC = 4'h1;
  localparam logic [3:0] OP_ORDER   = 4'h2;
  localparam logic [3:0] OP_STSTAT  = 4'h3;
  localparam logic [3:0] OP_STRNG   = 4'h4;
  localparam logic [3:0] OP_STRA    = 4'h5;
  localparam logic [3:0] OP_LDRA    = 4'h6;
  localparam logic [3:0] OP_STCNT   = 4'h7;
  localparam logic [3:0] OP_JSR     = 4'h8;
  localparam logic [3:0] OP_JSS     = 4'h9;
  localparam logic [3:0] OP_JSNR    = 4'hA;
  localparam logic [3:0] OP_JSNS    = 4'hB;
  localparam logic [3:0] OP_JCZ     = 4'hC;
  localparam logic [3:0] OP_JCNZ    = 4'hD;

  // ==========================================================================
  // Directive codes and field selections
  localparam logic [3:0] DIR_EXEC     = 4'h0;
  localparam logic [3:0] DIR_CHSTATE  = 4'h1;
  localparam logic [3:0] DIR_CHSTATUS = 4'h2;
  localparam logic [3:0] DIR_CHBOTH   = 4'h3;
  localparam logic [3:0] DIR_IN       = 4'h8;
  localparam logic [3:0] DIR_OUT      = 4'h9;
  localparam logic [3:0] DIR_INDN     = 4'hA;
  localparam logic [3:0] DIR_INUP     = 4'hB;

  localparam logic [2:0] FS_FULL  = 3'h0;
  localparam logic [2:0] FS_LHALF = 3'h1;
  localparam logic [2:0] FS_RHALF = 3'h2;
  localparam logic [2:0] FS_BYTE0 = 3'h3;
  localparam logic [2:0] FS_BYTE1 = 3'h4;
  localparam logic [2:0] FS_BYTE2 = 3'h5;
  localparam logic [2:0] FS_BYTE3 = 3'h6;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_SEL  = 8'h08;
  localparam logic [7:0] REG_CS1  = 8'h0C;
  localparam logic [7:0] REG_CS2  = 8'h10;
  localparam logic       CTRL_RST = 1'b0;

  // ==========================================================================
  // Word layouts; the leftmost printed bit 0 is the MSB here
  typedef struct packed {
    logic [3:0]    operation_code;
    logic [7:0]    arg;
    logic          spare;
    logic [AW-1:0] addr;
  } icce_cmd_t;

  typedef struct packed {
    logic [7:0]    status;
    logic [3:0]    loop_count;
    logic          spare;
    logic [AW-1:0] pointer;
  } icce_cs1_t;

  typedef struct packed {
    logic [11:0]   range_value;
    logic [AW-1:0] data_address;
    logic          flag;
  } icce_cs2_t;

  typedef struct packed {
    logic          req;
    logic          we;
    logic [AW-1:0] addr;
    logic [31:0]   wdata;
  } icce_mem_t;

  typedef struct packed {
    logic [CH_W-1:0] chan;
    logic [3:0]      dir;
    logic [2:0]      fsel;
    logic [31:0]     data;
  } icce_svc_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] word;
  } icce_iob_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_CMD, ST_IOB, ST_SRD, ST_DRD, ST_MWR, ST_OUT
  } icce_st_t;

endpackage

// file: icce_engine.sv
// Channel program engine: command fetch/execute, service directives, APB.
// Assumes a memory director with req/ack handshake and a one-cycle ack.
// Notes on behaviour
// - Process-control command puts whole command word on the I/O bus.
// - Order-transmit command puts whole command word on the I/O bus.
// - Store status writes status into word bits 0-7, keeps 8-31.
// - Store range writes range into bits 0-11, keeps 12-31.
// - Store range and address writes bits 0-30, forces bit 31 one.
// - Load range and address: inverted range, address, set flag bit.
// - Store count writes count into bits 8-11, then loads new count.
// - Jump on status reset/not reset tests status AND mask.
// - Jump on status set/not set tests mask AND inverted status.
// - Jump on count zero increments count, jumps if now zero.
// - Jump on count nonzero increments count, jumps if nonzero.
// - Requester supplies channel and directive with the request; engine takes them with acknowledge and acts.
// - Execute: fetch at pointer, increment, run; refused order restores pointer.
// - Change-state directive causes no action here.
// - Change-status writes supplied status into channel status field.
// - Change state and status updates status like a status change.
// - Transfer directive gives channel, type, field; uses address and range.
// - Plain input replaces field, plain output sends field; no counting.
// - Input count down: store, address minus one, range plus one, chain.
// - Input count up: store, address and range plus one, chain.
// - First stateword holds 8-bit status, 4-bit count, 19-bit pointer.
`timescale 1ns/1ps
module icce_engine
  import icce_pkg::*;
(
  input  wire logic        clk,        // 200 MHz clock
  input  wire logic        arst_n,     // Async reset, active low
  input  wire logic [7:0]  paddr,      // APB address
  input  wire logic        psel,       // APB select
  input  wire logic        penable,    // APB enable
  input  wire logic        pwrite,     // APB write
  input  wire logic [31:0] pwdata,     // APB write data
  output logic      [31:0] prdata,     // APB read data
  output logic             pready,     // APB ready
  output logic             pslverr,    // APB error
  output icce_mem_t        mem_o,      // Memory request
  input  wire logic        mem_ack,    // Memory acknowledge
  input  wire logic [31:0] mem_rdata,  // Memory read data
  input  wire logic        svc_req,    // Service request
  input  icce_svc_t        svc_i,      // Channel, directive, field, data
  output logic             svc_ack,    // Service request taken
  output logic             svc_done,   // Directive finished
  output icce_iob_t        iob_o,      // I/O bus command word
  input  wire logic        iob_ack,    // I/O bus word taken
  input  wire logic        iob_accept, // Order accepted with iob_ack
  output logic             out_valid,  // Output data valid
  output logic      [31:0] out_data,   // Output field, right aligned
  input  wire logic        out_ready   // Controller takes output data
);

  // ==========================================================================
  // State
  typedef struct packed {
    icce_st_t               st;
    logic                   en;
    logic                   err;
    logic [CH_W-1:0]        sel;
    logic                   from_cmd;
    logic [CH_W-1:0]        chan;
    logic [3:0]             dir;
    logic [2:0]             fsel;
    logic [31:0]            sdata;
    icce_cmd_t              cmd;
    logic [31:0]            rd;
    icce_mem_t              mreq;
    icce_iob_t              iob;
    logic                   out_valid;
    logic [31:0]            out_data;
    logic                   done;
    logic [31:0]            prdata;
    icce_cs1_t [CH_N-1:0]   cs1;
    icce_cs2_t [CH_N-1:0]   cs2;
  } icce_state_t;

  icce_state_t s_ff;
  icce_state_t nxt_s;
  icce_cs1_t   cur1;
  icce_cs2_t   cur2;
  logic        svc_take;
  logic        apb_wr;
  logic        apb_hit;
  logic [31:0] apb_rd;

  function automatic logic [31:0] fld_mask(input logic [2:0] fs);
    case (fs)
      FS_FULL:  fld_mask = 32'hFFFFFFFF;
      FS_LHALF,
      FS_RHALF: fld_mask = 32'h0000FFFF;
      FS_BYTE0,
      FS_BYTE1,
      FS_BYTE2,
      FS_BYTE3: fld_mask = 32'h000000FF;
      default:  fld_mask = 32'h00000000;
    endcase
  endfunction

  function automatic logic [4:0] fld_shift(input logic [2:0] fs);
    case (fs)
      FS_LHALF: fld_shift = 5'h10;
      FS_BYTE0: fld_shift = 5'h18;
      FS_BYTE1: fld_shift = 5'h10;
      FS_BYTE2: fld_shift = 5'h08;
      default:  fld_shift = 5'h00;
    endcase
  endfunction

  assign cur1     = s_ff.cs1[s_ff.chan];
  assign cur2     = s_ff.cs2[s_ff.chan];
  assign svc_take = (s_ff.st == ST_IDLE) && s_ff.en && svc_req;
  assign svc_ack  = svc_take;

  // ==========================================================================
  // APB slave: one wait-free access phase, read data latched in setup
  assign apb_wr  = psel && penable && pwrite;
  assign apb_hit = (paddr == REG_CTRL) || (paddr == REG_STAT) ||
                   (paddr == REG_SEL) || (paddr == REG_CS1) ||
                   (paddr == REG_CS2);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !apb_hit;
  assign prdata  = s_ff.prdata;

  always_comb begin
    case (paddr)
      REG_CTRL: apb_rd = {31'h00000000, s_ff.en};
      REG_STAT: apb_rd = {{(29-CH_W){1'b0}}, s_ff.chan, s_ff.err,
                          1'b0, (s_ff.st != ST_IDLE)};
      REG_SEL:  apb_rd = {{(32-CH_W){1'b0}}, s_ff.sel};
      REG_CS1:  apb_rd = s_ff.cs1[s_ff.sel];
      REG_CS2:  apb_rd = s_ff.cs2[s_ff.sel];
      default:  apb_rd = 32'h00000000;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    logic [3:0]  cnt;
    logic [11:0] rng;
    logic [31:0] msk;
    logic [4:0]  sh;
    nxt_s      = s_ff;
    nxt_s.done = 1'b0;
    cnt        = 4'h0;
    rng        = 12'h000;
    msk        = fld_mask(s_ff.fsel);
    sh         = fld_shift(s_ff.fsel);

    if (psel && !penable) begin
      nxt_s.prdata = apb_rd;
    end
    if (apb_wr) begin
      case (paddr)
        REG_CTRL: nxt_s.en = pwdata[0];
        REG_STAT: begin
          if (pwdata[2]) begin
            nxt_s.err = 1'b0;
          end
        end
        REG_SEL:  nxt_s.sel = pwdata[CH_W-1:0];
        REG_CS1:  nxt_s.cs1[s_ff.sel] = pwdata;
        REG_CS2:  nxt_s.cs2[s_ff.sel] = pwdata;
        default:  nxt_s.en = s_ff.en;
      endcase
    end

    case (s_ff.st)
      ST_IDLE: begin
        if (svc_take) begin
          nxt_s.chan     = svc_i.chan;
          nxt_s.dir      = svc_i.dir;
          nxt_s.fsel     = svc_i.fsel;
          nxt_s.sdata    = svc_i.data;
          nxt_s.from_cmd = 1'b0;
          case (svc_i.dir)
            DIR_EXEC: begin
              nxt_s.from_cmd = 1'b1;
              nxt_s.mreq = '{req: 1'b1, we: 1'b0,
                             addr: s_ff.cs1[svc_i.chan].pointer,
                             wdata: 32'h00000000};
              nxt_s.cs1[svc_i.chan].pointer =
                s_ff.cs1[svc_i.chan].pointer + 19'h00001;
              nxt_s.st = ST_FETCH;
            end
            DIR_CHSTATUS,
            DIR_CHBOTH: begin
              nxt_s.cs1[svc_i.chan].status = svc_i.data[7:0];
              nxt_s.done = 1'b1;
            end
            DIR_IN,
            DIR_OUT,
            DIR_INDN,
            DIR_INUP: begin
              nxt_s.mreq = '{req: 1'b1, we: 1'b0,
                             addr: s_ff.cs2[svc_i.chan].data_address,
                             wdata: 32'h00000000};
              nxt_s.st = ST_DRD;
            end
            default: nxt_s.done = 1'b1;
          endcase
        end
      end

      ST_FETCH: begin
        if (mem_ack) begin
          nxt_s.mreq.req = 1'b0;
          nxt_s.cmd      = mem_rdata;
          nxt_s.st       = ST_CMD;
        end
      end

      ST_CMD: begin
        nxt_s.st   = ST_IDLE;
        nxt_s.done = 1'b1;
        case (s_ff.cmd.operation_code)
          OP_CTLPROC,
          OP_ORDER: begin
            nxt_s.iob  = '{valid: 1'b1, word: s_ff.cmd};
            nxt_s.st   = ST_IOB;
            nxt_s.done = 1'b0;
          end
          OP_STSTAT,
          OP_STRNG,
          OP_STRA,
          OP_STCNT: begin
            nxt_s.mreq = '{req: 1'b1, we: 1'b0, addr: s_ff.cmd.addr,
                           wdata: 32'h00000000};
            nxt_s.st   = ST_SRD;
            nxt_s.done = 1'b0;
          end
          OP_LDRA: begin
            nxt_s.cs2[s_ff.chan] = '{range_value: ~{4'h0, s_ff.cmd.arg},
                                     data_address: s_ff.cmd.addr,
                                     flag: 1'b1};
          end
          OP_JSR: begin
            if ((cur1.status & s_ff.cmd.arg) == 8'h00) begin
              nxt_s.cs1[s_ff.chan].pointer = s_ff.cmd.addr;
            end
          end
          OP_JSNR: begin
            if ((cur1.status & s_ff.cmd.arg) != 8'h00) begin
              nxt_s.cs1[s_ff.chan].pointer = s_ff.cmd.addr;
            end
          end
          OP_JSS: begin
            if ((~cur1.status & s_ff.cmd.arg) == 8'h00) begin
              nxt_s.cs1[s_ff.chan].pointer = s_ff.cmd.addr;
            end
          end
          OP_JSNS: begin
            if ((~cur1.status & s_ff.cmd.arg) != 8'h00) begin
              nxt_s.cs1[s_ff.chan].pointer = s_ff.cmd.addr;
            end
          end
          OP_JCZ,
          OP_JCNZ: begin
            cnt = cur1.loop_count + 4'h1;
            nxt_s.cs1[s_ff.chan].loop_count = cnt;
            if ((cnt == 4'h0) == (s_ff.cmd.operation_code == OP_JCZ)) begin
              nxt_s.cs1[s_ff.chan].pointer = s_ff.cmd.addr;
            end
          end
          default: nxt_s.done = 1'b1;
        endcase
      end

      ST_IOB: begin
        if (iob_ack) begin
          nxt_s.iob.valid = 1'b0;
          if (s_ff.cmd.operation_code == OP_ORDER && !iob_accept) begin
            nxt_s.cs1[s_ff.chan].pointer = cur1.pointer - 19'h00001;
            nxt_s.err = 1'b1;
          end
          nxt_s.st   = ST_IDLE;
          nxt_s.done = 1'b1;
        end
      end

      ST_SRD: begin
        if (mem_ack) begin
          nxt_s.rd      = mem_rdata;
          nxt_s.mreq.we = 1'b1;
          case (s_ff.cmd.operation_code)
            OP_STSTAT: nxt_s.mreq.wdata = {cur1.status,
                                           mem_rdata[23:0]};
            OP_STRNG:  nxt_s.mreq.wdata = {cur2.range_value,
                                           mem_rdata[19:0]};
            OP_STRA:   nxt_s.mreq.wdata = {cur2[31:1], 1'b1};
            default:   nxt_s.mreq.wdata = {mem_rdata[31:24], cur1.loop_count,
                                           mem_rdata[19:0]};
          endcase
          nxt_s.st = ST_MWR;
        end
      end

      ST_DRD: begin
        if (mem_ack) begin
          nxt_s.rd = mem_rdata;
          if (s_ff.dir == DIR_OUT) begin
            nxt_s.mreq.req   = 1'b0;
            nxt_s.out_data   = (mem_rdata >> sh) & msk;
            nxt_s.out_valid  = 1'b1;
            nxt_s.st         = ST_OUT;
          end else begin
            nxt_s.mreq.we    = 1'b1;
            nxt_s.mreq.wdata = (mem_rdata & ~(msk << sh)) |
                               ((s_ff.sdata & msk) << sh);
            nxt_s.st         = ST_MWR;
          end
        end
      end

      ST_MWR: begin
        if (mem_ack) begin
          nxt_s.mreq = '{req: 1'b0, we: 1'b0, addr: s_ff.mreq.addr,
                         wdata: 32'h00000000};
          nxt_s.st   = ST_IDLE;
          nxt_s.done = 1'b1;
          if (s_ff.from_cmd) begin
            if (s_ff.cmd.operation_code == OP_STCNT) begin
              nxt_s.cs1[s_ff.chan].loop_count = s_ff.cmd.arg[7:4];
            end
          end else if (s_ff.dir == DIR_INDN || s_ff.dir == DIR_INUP) begin
            rng = cur2.range_value + 12'h001;
            nxt_s.cs2[s_ff.chan].range_value = rng;
            nxt_s.cs2[s_ff.chan].data_address = (s_ff.dir == DIR_INUP) ?
              cur2.data_address + 19'h00001 :
              cur2.data_address - 19'h00001;
            if (&rng) begin
              nxt_s.from_cmd = 1'b1;
              nxt_s.mreq = '{req: 1'b1, we: 1'b0, addr: cur1.pointer,
                             wdata: 32'h00000000};
              nxt_s.cs1[s_ff.chan].pointer = cur1.pointer + 19'h00001;
              nxt_s.st   = ST_FETCH;
              nxt_s.done = 1'b0;
            end
          end
        end
      end

      ST_OUT: begin
        if (out_ready) begin
          nxt_s.out_valid = 1'b0;
          nxt_s.st        = ST_IDLE;
          nxt_s.done      = 1'b1;
        end
      end

      default: nxt_s.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_ff    <= '0;
      s_ff.st <= ST_IDLE;
      s_ff.en <= CTRL_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign mem_o     = s_ff.mreq;
  assign iob_o     = s_ff.iob;
  assign out_valid = s_ff.out_valid;
  assign out_data  = s_ff.out_data;
  assign svc_done  = s_ff.done;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  ctlproc_word_a: assert property (
    s_ff.st == ST_CMD && s_ff.cmd.operation_code == OP_CTLPROC
    |=> iob_o.valid && iob_o.word == $past(s_ff.cmd))
    else $error("process control word not on bus");

  order_word_a: assert property (
    s_ff.st == ST_CMD && s_ff.cmd.operation_code == OP_ORDER
    |=> iob_o.valid && iob_o.word == $past(s_ff.cmd) throughout
        (s_ff.st == ST_IOB)[*1])
    else $error("order word not on bus");

  status_store_a: assert property (
    s_ff.st == ST_MWR && s_ff.from_cmd &&
    s_ff.cmd.operation_code == OP_STSTAT
    |-> mem_o.we && mem_o.wdata[31:24] == cur1.status &&
        mem_o.wdata[23:0] == s_ff.rd[23:0])
    else $error("status store word wrong");

  range_store_a: assert property (
    s_ff.st == ST_MWR && s_ff.from_cmd &&
    s_ff.cmd.operation_code == OP_STRNG
    |-> mem_o.wdata == {cur2.range_value, s_ff.rd[19:0]})
    else $error("range store word wrong");

  rngaddr_store_a: assert property (
    s_ff.st == ST_MWR && s_ff.from_cmd &&
    s_ff.cmd.operation_code == OP_STRA
    |-> mem_o.wdata[0] && mem_o.wdata[31:1] == cur2[31:1])
    else $error("range and address store wrong");

  load_range_a: assert property (
    s_ff.st == ST_CMD && s_ff.cmd.operation_code == OP_LDRA && !apb_wr
    |=> s_ff.cs2[$past(s_ff.chan)].flag &&
        s_ff.cs2[$past(s_ff.chan)].range_value ==
        ~{4'h0, $past(s_ff.cmd.arg)})
    else $error("load range and address wrong");

  status_jump_a: assert property (
    s_ff.st == ST_CMD && s_ff.cmd.operation_code == OP_JSR && !apb_wr &&
    (cur1.status & s_ff.cmd.arg) == 8'h00
    |=> s_ff.cs1[$past(s_ff.chan)].pointer == $past(s_ff.cmd.addr))
    else $error("jump on status reset not taken");

  count_jump_a: assert property (
    s_ff.st == ST_CMD && s_ff.cmd.operation_code == OP_JCZ && !apb_wr
    |=> s_ff.cs1[$past(s_ff.chan)].loop_count ==
        $past(cur1.loop_count) + 4'h1)
    else $error("loop count not incremented");

  order_restore_a: assert property (
    s_ff.st == ST_IOB && s_ff.cmd.operation_code == OP_ORDER &&
    iob_ack && !iob_accept && !apb_wr
    |=> s_ff.cs1[$past(s_ff.chan)].pointer == $past(cur1.pointer) - 19'h1
        && s_ff.err)
    else $error("refused order did not restore pointer");

endmodule

// file: icce_partner.sv
// Far side of the channel engine: word memory, I/O bus, output taker.
// Assumes the engine holds each request until its ack; slow adds waits.
`timescale 1ns/1ps
module icce_partner
  import icce_pkg::*;
(
  input  wire logic        clk,        // Clock
  input  icce_mem_t        mem_o,      // Memory request
  output logic             mem_ack,    // Memory ack pulse
  output logic      [31:0] mem_rdata,  // Memory read data
  input  icce_iob_t        iob_o,      // Command word
  output logic             iob_ack,    // Word taken
  output logic             iob_accept, // Order accepted
  input  wire logic        accept,     // Accept orders when high
  input  wire logic        slow,       // Answer after wait cycles
  input  wire logic        out_valid,  // Output field valid
  input  wire logic [31:0] out_data,   // Output field
  output logic             out_ready   // Output field taken
);
  logic [31:0] mem [0:63];
  logic [31:0] iob_word;
  logic [31:0] out_word;
  logic [1:0]  wt;
  logic        go;

  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    iob_ack = 1'b0;
    iob_accept = 1'b0;
    out_ready = 1'b0;
    wt = 2'h0;
  end

  assign go = !slow || wt == 2'h3;

  always @(posedge clk) begin
    mem_ack <= 1'b0;
    iob_ack <= 1'b0;
    iob_accept <= 1'b0;
    out_ready <= 1'b0;
    // Stale read data must not look valid
    mem_rdata <= ~mem_rdata;
    wt <= (mem_o.req || iob_o.valid) ? wt + 2'h1 : 2'h0;
    if (mem_o.req && !mem_ack && go) begin
      mem_ack <= 1'b1;
      wt <= 2'h0;
      if (mem_o.we)
        mem[mem_o.addr[5:0]] <= mem_o.wdata;
      else
        mem_rdata <= mem[mem_o.addr[5:0]];
    end
    if (iob_o.valid && !iob_ack && go) begin
      iob_ack <= 1'b1;
      iob_accept <= accept;
      iob_word <= iob_o.word;
      wt <= 2'h0;
    end
    if (out_valid && !out_ready) begin
      out_ready <= 1'b1;
      out_word <= out_data;
    end
  end
endmodule

// file: icce_engine_tb.sv
// Self-checking bench of the channel engine over APB and service requests.
// Assumes icce_partner stands for memory, I/O bus and output controller.
`timescale 1ns/1ps
module icce_engine_tb
  import icce_pkg::*;
;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, mem_rdata, out_data, rd, c1q, c2q;
  logic        mem_ack, svc_req, svc_ack, svc_done, iob_ack, iob_accept;
  logic        out_valid, out_ready, accept, slow;
  logic [2:0]  ch;
  icce_mem_t   mem_o;
  icce_svc_t   svc_i;
  icce_iob_t   iob_o;
  int          bad_count, comparisons, cycles;

  icce_engine i_icce_engine (.clk, .arst_n, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .mem_o, .mem_ack,
    .mem_rdata, .svc_req, .svc_i, .svc_ack, .svc_done, .iob_o, .iob_ack,
    .iob_accept, .out_valid, .out_data, .out_ready);
  icce_partner i_icce_partner (.clk, .mem_o, .mem_ack, .mem_rdata, .iob_o,
    .iob_ack, .iob_accept, .accept, .slow, .out_valid, .out_data,
    .out_ready);

  // ==========================================================================
  // Clock, timeout, report
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ==========================================================================
  // Bus tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic svc(input logic [3:0] dr, input logic [2:0] fs,
                     input logic [31:0] d);
    int n;
    svc_req <= 1'b1;
    svc_i <= {ch, dr, fs, d};
    @(posedge clk);
    while (svc_ack !== 1'b1) @(posedge clk);
    svc_req <= 1'b0;
    svc_i <= ~svc_i;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (svc_done !== 1'b1 && n < 300);
    check(svc_done, 32'h1);
  endtask

  task automatic exec(input logic [31:0] c1, c2, cmd);
    apb(1'b1, REG_CS1, c1);
    apb(1'b1, REG_CS2, c2);
    i_icce_partner.mem[c1[5:0]] = cmd;
    svc(DIR_EXEC, FS_FULL, 32'h0);
    apb(1'b0, REG_CS1, 32'h0);
    c1q = rd;
    apb(1'b0, REG_CS2, 32'h0);
    c2q = rd;
  endtask

  task automatic xfer(input logic [31:0] c2, input logic [3:0] dr,
                      input logic [2:0] fs, input logic [31:0] d);
    apb(1'b1, REG_CS2, c2);
    svc(dr, fs, d);
    apb(1'b0, REG_CS2, 32'h0);
    c2q = rd;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b1, REG_SEL, 32'h0);
    apb(1'b1, REG_CS1, 32'hA5300010);
    apb(1'b0, REG_CS1, 32'h0);
    check(rd, 32'hA5300010);
    apb(1'b0, 8'hFC, 32'h0);
    check(err, 32'h1);
  endtask

  task automatic t_store;
    i_icce_partner.mem[32] = 32'h12345678;
    exec(32'hA5300010, 32'h0, {OP_STSTAT, 8'h00, 1'b0, 19'h20});
    check(i_icce_partner.mem[32], 32'hA5345678);
    check(c1q, 32'hA5300011);
    slow <= 1'b1;
    i_icce_partner.mem[33] = 32'h11111111;
    exec(32'h12, 32'hABC12344, {OP_STRNG, 8'h00, 1'b0, 19'h21});
    check(i_icce_partner.mem[33], 32'hABC11111);
    exec(32'h13, 32'hABC12344, {OP_STRA, 8'h00, 1'b0, 19'h21});
    check(i_icce_partner.mem[33], 32'hABC12345);
    i_icce_partner.mem[34] = 32'hFFFFFFFF;
    exec(32'h00300014, 32'h0, {OP_STCNT, 8'h90, 1'b0, 19'h22});
    check(i_icce_partner.mem[34], 32'hFF3FFFFF);
    check(c1q[23:20], 32'h9);
    exec(32'h15, 32'h0, {OP_LDRA, 8'h5A, 1'b0, 19'h0ABCD});
    check(c2q, {~{4'h0, 8'h5A}, 19'h0ABCD, 1'b1});
    slow <= 1'b0;
  endtask

  task automatic t_jump;
    logic [7:0] mk;
    logic       z;
    logic       j;
    for (int k = 0; k < 8; k++) begin
      mk = k[2] ? 8'h03 : 8'h30;
      z = ((k[0] ? ~8'h0F : 8'h0F) & mk) == 8'h00;
      j = k[1] ? !z : z;
      exec(32'h0F000030, 32'h0, {OP_JSR + 4'(k[1:0]), mk, 1'b0, 19'h40});
      check(c1q[18:0], j ? 19'h40 : 19'h31);
    end
  endtask

  task automatic t_count;
    logic [3:0] c;
    logic       j;
    for (int k = 0; k < 4; k++) begin
      c = k[0] ? 4'hF : 4'h3;
      j = k[1] ? (c + 4'h1 != 4'h0) : (c + 4'h1 == 4'h0);
      exec({8'h00, c, 20'h30}, 32'h0, {OP_JCZ + 4'(k[1]), 8'h0, 1'b0, 19'h40});
      check(c1q[23:20], 4'(c + 4'h1));
      check(c1q[18:0], j ? 19'h40 : 19'h31);
    end
  endtask

  task automatic t_order;
    accept <= 1'b0;
    exec(32'h16, 32'h0, {OP_ORDER, 8'h5C, 1'b0, 19'h01234});
    check(i_icce_partner.iob_word, {OP_ORDER, 8'h5C, 1'b0, 19'h01234});
    check(c1q, 32'h16);
    apb(1'b0, REG_STAT, 32'h0);
    check(rd[2], 32'h1);
    apb(1'b1, REG_STAT, 32'h4);
    apb(1'b0, REG_STAT, 32'h0);
    check(rd[2], 32'h0);
    accept <= 1'b1;
    exec(32'h16, 32'h0, {OP_ORDER, 8'h5C, 1'b0, 19'h01234});
    check(c1q, 32'h17);
    exec(32'h17, 32'h0, {OP_CTLPROC, 8'h3C, 1'b0, 19'h0});
    check(i_icce_partner.iob_word, {OP_CTLPROC, 8'h3C, 1'b0, 19'h0});
  endtask

  task automatic t_status;
    ch = 3'h5;
    apb(1'b1, REG_SEL, 32'h5);
    svc(DIR_CHSTATUS, FS_FULL, 32'h3C);
    apb(1'b0, REG_CS1, 32'h0);
    check(rd[31:24], 8'h3C);
    svc(DIR_CHBOTH, FS_FULL, 32'hC3);
    apb(1'b0, REG_CS1, 32'h0);
    check(rd[31:24], 8'hC3);
    svc(DIR_CHSTATE, FS_FULL, 32'h77);
    apb(1'b0, REG_CS1, 32'h0);
    check(rd[31:24], 8'hC3);
    ch = 3'h0;
    apb(1'b1, REG_SEL, 32'h0);
  endtask

  task automatic t_xfer;
    slow <= 1'b1;
    i_icce_partner.mem[40] = 32'h11223344;
    xfer({12'h100, 19'h28, 1'b0}, DIR_IN, FS_BYTE1, 32'hAA);
    check(i_icce_partner.mem[40], 32'h11AA3344);
    check(c2q, {12'h100, 19'h28, 1'b0});
    xfer({12'h100, 19'h28, 1'b0}, DIR_OUT, FS_LHALF, 32'h0);
    check(i_icce_partner.out_word, 32'h11AA);
    xfer({12'h100, 19'h28, 1'b0}, DIR_INDN, FS_RHALF, 32'hBEEF);
    check(i_icce_partner.mem[40], 32'h11AABEEF);
    check(c2q, {12'h101, 19'h27, 1'b0});
    apb(1'b1, REG_CS1, 32'h30);
    i_icce_partner.mem[48] = {OP_JSR, 8'h00, 1'b0, 19'h45};
    xfer({12'hFFE, 19'h27, 1'b0}, DIR_INUP, FS_FULL, 32'hCAFEF00D);
    check(i_icce_partner.mem[39], 32'hCAFEF00D);
    check(c2q, {12'hFFF, 19'h28, 1'b0});
    apb(1'b0, REG_CS1, 32'h0);
    check(rd[18:0], 19'h45);
    slow <= 1'b0;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    arst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    svc_req = 1'b0;
    svc_i = '0;
    accept = 1'b1;
    slow = 1'b0;
    ch = 3'h0;
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_store();
    t_jump();
    t_count();
    t_order();
    t_status();
    t_xfer();
    report_and_stop();
  end
endmodule
